/* File: design/poss_consts.svh */
// Constants for the power-on and soft start sequencer.
// Assumes a single 125 MHz system clock; included by bare name.
`ifndef POSS_CONSTS_SVH
`define POSS_CONSTS_SVH

// Register map
`define POSS_CFG_OFFSET   8'h2C
`define POSS_CFG_RESET    8'h00
`define POSS_RD_UNMAPPED  8'h00

// Field positions inside the configuration register
`define POSS_SRC_HI       7
`define POSS_SRC_LO       6
`define POSS_SWON_BIT     5
`define POSS_DLY_HI       4
`define POSS_DLY_LO       3
`define POSS_SSTOP_BIT    2
`define POSS_RAMP_HI      1
`define POSS_RAMP_LO      0

// Enable source codes
`define POSS_SRC_ALWAYS   2'h0
`define POSS_SRC_PIN      2'h1
`define POSS_SRC_SW       2'h2
`define POSS_SRC_BOTH     2'h3

// Clock rate and documented times
`define POSS_CLK_MHZ      125
`define POSS_DLY1_MS      500
`define POSS_DLY2_MS      1000
`define POSS_DLY3_MS      2000
`define POSS_RAMP0_US     360
`define POSS_RAMP1_US     10000
`define POSS_RAMP2_US     20000
`define POSS_RAMP3_US     40000

// Ramp resolution: fraction runs 0..POSS_FRAC_FULL
`define POSS_FRAC_SHIFT   8
`define POSS_FRAC_FULL    9'h100
`define POSS_FRAC_ZERO    9'h000

`endif

/* File: design/poss_pkg.sv */
// Types for the power-on and soft start sequencer.
// Shared by the sequencer and its bench.
package poss_pkg;
   typedef enum logic [2:0] {
      POSS_OFF       = 3'b000,
      POSS_DELAY     = 3'b001,
      POSS_RAMP_UP   = 3'b010,
      POSS_ON        = 3'b011,
      POSS_RAMP_DOWN = 3'b100
   } poss_state_t;
endpackage

/* File: design/poss_sequencer.sv */
// Power-on enable selection, start delay, soft start and soft stop.
// Assumes pin input is asynchronous, fault input is on clk_sys.
// Operation
// - Source 10: software bit 5 alone enables
// - Source 00 always on; 01 pin only
// - Source 11: pin AND software bit
// - Delay 0/0.5/1/2 s before soft start
// - Soft stop also on fault shutdowns
// - Soft stop lasts the programmed ramp time
// - No soft stop: PWM off at once
// - Ramp time 360us/10ms/20ms/40ms to nominal
`timescale 1ns/1ns
`default_nettype none
`include "poss_consts.svh"
module poss_sequencer #(
   parameter int REF_W    = 12,
   parameter int DLY1_CYC = `POSS_DLY1_MS * `POSS_CLK_MHZ * 1000,
   parameter int DLY2_CYC = `POSS_DLY2_MS * `POSS_CLK_MHZ * 1000,
   parameter int DLY3_CYC = `POSS_DLY3_MS * `POSS_CLK_MHZ * 1000,
   parameter int RMP0_CYC = `POSS_RAMP0_US * `POSS_CLK_MHZ,
   parameter int RMP1_CYC = `POSS_RAMP1_US * `POSS_CLK_MHZ,
   parameter int RMP2_CYC = `POSS_RAMP2_US * `POSS_CLK_MHZ,
   parameter int RMP3_CYC = `POSS_RAMP3_US * `POSS_CLK_MHZ
) (
   input  wire logic               clk_sys,
   input  wire logic               rst,
   input  wire logic               power_on_input_pin,
   input  wire logic               faultShutdown,
   input  wire logic [REF_W-1:0]   nominalRef,
   input  wire logic [7:0]         regAddr,
   input  wire logic               regWrEn,
   input  wire logic [7:0]         regWrData,
   output logic      [7:0]         regRdData,
   output logic                    pwmEnable,
   output logic      [REF_W-1:0]   outRef,
   output logic                    power_on_request,
   output poss_pkg::poss_state_t   seqState
);
   import poss_pkg::*;

   localparam int CNT_W = 28;
   // Step period per ramp code; at least one cycle per step
   localparam int STP0 = (RMP0_CYC >> `POSS_FRAC_SHIFT) > 0 ? (RMP0_CYC >> `POSS_FRAC_SHIFT) : 1;
   localparam int STP1 = (RMP1_CYC >> `POSS_FRAC_SHIFT) > 0 ? (RMP1_CYC >> `POSS_FRAC_SHIFT) : 1;
   localparam int STP2 = (RMP2_CYC >> `POSS_FRAC_SHIFT) > 0 ? (RMP2_CYC >> `POSS_FRAC_SHIFT) : 1;
   localparam int STP3 = (RMP3_CYC >> `POSS_FRAC_SHIFT) > 0 ? (RMP3_CYC >> `POSS_FRAC_SHIFT) : 1;

   logic [7:0]         cfg;
   logic               pinSync;
   logic [1:0]         srcSel;
   logic [1:0]         dlySel;
   logic [1:0]         rampSel;
   logic               swOn;
   logic               softStopEn;
   logic               next_request;
   logic [CNT_W-1:0]   dlyLoad;
   logic [CNT_W-1:0]   stepLoad;
   logic [CNT_W-1:0]   cnt;
   logic [8:0]         frac;
   logic               stepDue;
   logic               shutdown;
   poss_state_t        state;
   poss_state_t        next_state;
   logic [REF_W+8:0]   scaled;

   // Pin comes from the host, so it is synchronised first
   poss_sync2 #(.W(1)) uPinSync (
      .clk_sys (clk_sys),
      .rst     (rst),
      .asyncIn (power_on_input_pin),
      .syncOut (pinSync)
   );

   // Configuration register at its documented offset
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         cfg <= `POSS_CFG_RESET;
      end else if (regWrEn && regAddr == `POSS_CFG_OFFSET) begin
         cfg <= regWrData;
      end
   end

   // Read path; other offsets read as zero
   always_comb begin
      regRdData = (regAddr == `POSS_CFG_OFFSET) ? cfg : `POSS_RD_UNMAPPED;
   end

   assign srcSel     = cfg[`POSS_SRC_HI:`POSS_SRC_LO];
   assign swOn       = cfg[`POSS_SWON_BIT];
   assign dlySel     = cfg[`POSS_DLY_HI:`POSS_DLY_LO];
   assign softStopEn = cfg[`POSS_SSTOP_BIT];
   assign rampSel    = cfg[`POSS_RAMP_HI:`POSS_RAMP_LO];

   // Enable source selection
   always_comb begin
      case (srcSel)
         `POSS_SRC_ALWAYS: next_request = 1'b1;
         `POSS_SRC_PIN:    next_request = pinSync;
         `POSS_SRC_SW:     next_request = swOn;
         `POSS_SRC_BOTH:   next_request = swOn & pinSync;
         default:          next_request = 1'b0;
      endcase
   end

   // Registered so the state machine sees a clean level
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         power_on_request <= 1'b0;
      end else begin
         power_on_request <= next_request;
      end
   end

   // Delay and step lengths, as counts minus one
   always_comb begin
      case (dlySel)
         2'h1:    dlyLoad = CNT_W'(DLY1_CYC - 1);
         2'h2:    dlyLoad = CNT_W'(DLY2_CYC - 1);
         2'h3:    dlyLoad = CNT_W'(DLY3_CYC - 1);
         default: dlyLoad = '0;
      endcase
      case (rampSel)
         2'h0:    stepLoad = CNT_W'(STP0 - 1);
         2'h1:    stepLoad = CNT_W'(STP1 - 1);
         2'h2:    stepLoad = CNT_W'(STP2 - 1);
         default: stepLoad = CNT_W'(STP3 - 1);
      endcase
   end

   assign stepDue  = (cnt == '0);
   // Fault or loss of enable both count as a shutdown
   assign shutdown = faultShutdown | ~power_on_request;

   // Sequencing state machine
   always_comb begin
      next_state = state;
      case (state)
         POSS_OFF: begin
            if (!shutdown) begin
               next_state = (dlySel == 2'h0) ? POSS_RAMP_UP : POSS_DELAY;
            end
         end
         POSS_DELAY: begin
            if (shutdown) begin
               next_state = POSS_OFF;
            end else if (stepDue) begin
               next_state = POSS_RAMP_UP;
            end
         end
         POSS_RAMP_UP, POSS_ON: begin
            if (shutdown) begin
               next_state = softStopEn ? POSS_RAMP_DOWN : POSS_OFF;
            end else if (state == POSS_RAMP_UP && stepDue && frac == `POSS_FRAC_FULL) begin
               next_state = POSS_ON;
            end
         end
         POSS_RAMP_DOWN: begin
            // Runs to the end even if a fault is still present
            if (stepDue && frac == `POSS_FRAC_ZERO) begin
               next_state = POSS_OFF;
            end
         end
         default: next_state = POSS_OFF;
      endcase
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         state <= POSS_OFF;
      end else begin
         state <= next_state;
      end
   end

   // Shared timer: start delay, then ramp step period
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         cnt <= '0;
      end else if (state != next_state) begin
         cnt <= (next_state == POSS_DELAY) ? dlyLoad : stepLoad;
      end else if (stepDue) begin
         cnt <= stepLoad;
      end else begin
         cnt <= cnt - CNT_W'(1);
      end
   end

   // Ramp fraction: even steps up, same steps down
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         frac <= `POSS_FRAC_ZERO;
      end else if (state == POSS_OFF || state == POSS_DELAY || next_state == POSS_OFF) begin  // Quick restart from zero
         frac <= `POSS_FRAC_ZERO;
      end else if (state == POSS_RAMP_UP && stepDue && frac != `POSS_FRAC_FULL) begin
         frac <= frac + 9'h001;
      end else if (state == POSS_RAMP_DOWN && stepDue && frac != `POSS_FRAC_ZERO) begin
         frac <= frac - 9'h001;
      end
   end

   assign scaled = nominalRef * frac;

   // Outputs held in flops; hard stop drops everything at once
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         pwmEnable <= 1'b0;
         outRef    <= '0;
         seqState  <= POSS_OFF;
      end else begin
         seqState  <= next_state;
         pwmEnable <= (next_state == POSS_RAMP_UP) || (next_state == POSS_ON)
                      || (next_state == POSS_RAMP_DOWN);
         outRef    <= (next_state == POSS_OFF || next_state == POSS_DELAY) ? '0
                      : scaled[REF_W+`POSS_FRAC_SHIFT-1:`POSS_FRAC_SHIFT];
      end
   end
endmodule
`default_nettype wire

/* File: design/poss_sync2.sv */
// Two-flop synchroniser for asynchronous level inputs.
// Assumes the inputs are slow levels; no pulse catching.
`timescale 1ns/1ns
`default_nettype none
module poss_sync2 #(
   parameter int W = 1
) (
   input  wire logic         clk_sys,
   input  wire logic         rst,
   input  wire logic [W-1:0] asyncIn,
   output logic      [W-1:0] syncOut
);
   logic [W-1:0] meta;

   // First stage feeds only the second stage
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         meta    <= '0;
         syncOut <= '0;
      end else begin
         meta    <= asyncIn;
         syncOut <= meta;
      end
   end
endmodule
`default_nettype wire

/* File: dv/poss_checker.sv */
// Port checker for the power-on sequencer, bound to every instance.
// Assumes regAddr rests on the config offset between accesses.
`timescale 1ns/1ns
`default_nettype none
`include "poss_consts.svh"
module poss_checker #(
   parameter int REF_W = 12
) (
   input wire logic             clk_sys,
   input wire logic             rst,
   input wire logic             power_on_input_pin,
   input wire logic             faultShutdown,
   input wire logic [REF_W-1:0] nominalRef,
   input wire logic [7:0]       regAddr,
   input wire logic             regWrEn,
   input wire logic [7:0]       regWrData,
   input wire logic [7:0]       regRdData,
   input wire logic             pwmEnable,
   input wire logic [REF_W-1:0] outRef,
   input wire logic             power_on_request,
   input wire logic [2:0]       seqState
);
   import poss_pkg::*;
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (rst);
   // Config is visible only while the address rests on it
   logic cfgOk;
   assign cfgOk = regAddr == `POSS_CFG_OFFSET;
   sequence sStop;
      (seqState == POSS_ON || seqState == POSS_RAMP_UP) && (!power_on_request || faultShutdown);
   endsequence
   a_off_quiet: assert property (seqState == POSS_OFF |-> !pwmEnable && outRef == '0)
      else $error("outputs active while off");
   a_ramp_start: assert property ($rose(pwmEnable) |-> seqState == POSS_RAMP_UP && outRef == '0)
      else $error("ramp did not start from zero");
   a_ramp_mono: assert property (seqState == POSS_RAMP_UP && $past(seqState) == POSS_RAMP_UP
      && $stable(nominalRef) |-> outRef >= $past(outRef))
      else $error("ramp fell");
   a_hard_stop: assert property (cfgOk && !regRdData[2] ##0 sStop
      |=> seqState == POSS_OFF && !pwmEnable && outRef == '0)
      else $error("hard stop not immediate");
   a_soft_stop: assert property (cfgOk && regRdData[2] ##0 sStop |=> seqState == POSS_RAMP_DOWN && pwmEnable)
      else $error("soft stop missing");
   // Reset sampled high keeps the release edge out of the antecedent
   a_src_always: assert property (!rst && cfgOk && regRdData[7:6] == `POSS_SRC_ALWAYS |=> power_on_request)
      else $error("always-on source not on");
   a_src_sw: assert property (cfgOk && regRdData[7:6] == `POSS_SRC_SW |=> power_on_request == $past(regRdData[5]))
      else $error("software source not followed");
   a_src_pin: assert property ((cfgOk && regRdData[7:6] == `POSS_SRC_PIN && power_on_input_pin)[*4]
      |=> power_on_request)
      else $error("pin source not followed");
   a_src_both: assert property (cfgOk && regRdData[7:6] == `POSS_SRC_BOTH && !regRdData[5] |=> !power_on_request)
      else $error("both source on without bit");
   a_on_nominal: assert property (seqState == POSS_ON && $stable(nominalRef) |-> outRef == nominalRef)
      else $error("on level not nominal");
endmodule
bind poss_sequencer poss_checker #(.REF_W(REF_W)) u_poss_checker (
   .clk_sys            (clk_sys),
   .rst                (rst),
   .power_on_input_pin (power_on_input_pin),
   .faultShutdown      (faultShutdown),
   .nominalRef         (nominalRef),
   .regAddr            (regAddr),
   .regWrEn            (regWrEn),
   .regWrData          (regWrData),
   .regRdData          (regRdData),
   .pwmEnable          (pwmEnable),
   .outRef             (outRef),
   .power_on_request   (power_on_request),
   .seqState           (seqState)
);
`default_nettype wire

/* File: dv/poss_host.sv */
// Host model driving the power-on pin, prompt or slow.
// Assumes the pin idles low; drives on the rising edge.
`timescale 1ns/1ns
`default_nettype none
module poss_host (
   input  wire logic clk_sys,
   input  wire logic wantOn,
   input  wire logic slow,
   output logic      power_on_input_pin = 1'b0
);
   // Idle-low start without a second driving process
   logic [7:0] hist = 8'h00;
   // Slow mode lags the request by eight cycles
   always @(posedge clk_sys) begin
      hist <= {hist[6:0], wantOn};
      power_on_input_pin <= slow ? hist[7] : wantOn;
   end
endmodule
`default_nettype wire

/* File: dv/power_on_soft_start_control_test.sv */
// Bench for the power-on sequencer with short delay and ramp counts.
// Assumes the checker is bound and the host model drives the pin.
`timescale 1ns/1ns
`default_nettype none
module power_on_soft_start_control_test;
   import poss_pkg::*;
   localparam int DLY[4] = '{0, 1000, 2000, 4000};
   localparam int RMP[4] = '{512, 1024, 2048, 4096};
   logic clk_sys, rst, wantOn, slow, power_on_input_pin, faultShutdown, regWrEn, pwmEnable, power_on_request;
   logic [11:0] nominalRef, outRef;
   logic [7:0] regAddr, regWrData, regRdData;
   poss_state_t seqState;
   int bad_count, num_checks, n;
   poss_host u_poss_host (.clk_sys(clk_sys), .wantOn(wantOn), .slow(slow), .power_on_input_pin(power_on_input_pin));
   poss_sequencer #(.DLY1_CYC(DLY[1]), .DLY2_CYC(DLY[2]), .DLY3_CYC(DLY[3]), .RMP0_CYC(RMP[0]),
      .RMP1_CYC(RMP[1]), .RMP2_CYC(RMP[2]), .RMP3_CYC(RMP[3])) u_poss_sequencer (.clk_sys(clk_sys),
      .rst(rst), .power_on_input_pin(power_on_input_pin), .faultShutdown(faultShutdown),
      .nominalRef(nominalRef), .regAddr(regAddr), .regWrEn(regWrEn), .regWrData(regWrData),
      .regRdData(regRdData), .pwmEnable(pwmEnable), .outRef(outRef), .power_on_request(power_on_request),
      .seqState(seqState));
   initial begin
      clk_sys = 1'b0;
      forever #4 clk_sys = ~clk_sys;
   end
   task automatic chk(input logic [11:0] got, input logic [11:0] exp);
      num_checks++;
      if (got !== exp) begin
         bad_count++;
         $display("unexpected at %0t: got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [7:0] d);
      @(posedge clk_sys);
      regWrEn <= 1'b1;
      regWrData <= d;
      @(posedge clk_sys);
      regWrEn <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      @(posedge clk_sys);
      regAddr <= a;
      @(negedge clk_sys);
      chk(12'(regRdData), 12'(e));
      @(posedge clk_sys);
      regAddr <= 8'h2C;
   endtask
   // Bounded wait, then the state itself is compared
   task automatic waitst(input poss_state_t s, input int max);
      n = 0;
      while (seqState !== s && n < max) begin
         @(negedge clk_sys);
         n++;
      end
      chk(12'(seqState), 12'(s));
   endtask
   // Dwell time in a state, allowing lo/64 plus four cycles of slack
   task automatic dwell(input poss_state_t s, input int lo);
      n = 0;
      while (seqState === s && n < 9000) begin
         @(negedge clk_sys);
         n++;
      end
      chk(12'(n >= lo && n <= lo + lo / 64 + 4), 12'h001);
   endtask
   task automatic stop_test;
      $display("checks %0d mismatches %0d", num_checks, bad_count);
      if (bad_count == 0 && num_checks > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   initial begin
      repeat (50000) @(posedge clk_sys);
      bad_count++;
      stop_test;
   end
   initial begin
      {rst, wantOn, slow, faultShutdown, regWrEn, regWrData} = 13'h1000;
      nominalRef = 12'hABC;
      regAddr = 8'h2C;
      repeat (12) @(posedge clk_sys);
      rst <= 1'b0;
      rd(8'h2C, 8'h00);
      rd(8'h10, 8'h00);
      waitst(POSS_ON, 700);
      chk(outRef, 12'hABC);
      chk(12'(pwmEnable), 12'h001);
      wr(8'h40);
      waitst(POSS_OFF, 8);
      chk(12'(pwmEnable), 12'h000);
      chk(outRef, 12'h000);
      // Read back also realigns stimulus to a rising edge
      rd(8'h2C, 8'h40);
      wantOn <= 1'b1;
      waitst(POSS_RAMP_UP, 12);
      dwell(POSS_RAMP_UP, RMP[0]);
      wr(8'h44);
      wantOn <= 1'b0;
      waitst(POSS_RAMP_DOWN, 12);
      dwell(POSS_RAMP_DOWN, RMP[0]);
      // Delay and ramp codes 1 to 3, started by the software bit
      for (int d = 1; d < 4; d++) begin
         wr(8'(8'h80 | (d << 3) | d));
         waitst(POSS_OFF, 8);
         wr(8'(8'hA0 | (d << 3) | d));
         waitst(POSS_DELAY, 8);
         dwell(POSS_DELAY, DLY[d]);
         dwell(POSS_RAMP_UP, RMP[d]);
      end
      wr(8'hA4);
      faultShutdown <= 1'b1;
      waitst(POSS_RAMP_DOWN, 8);
      waitst(POSS_OFF, 700);
      @(posedge clk_sys);
      faultShutdown <= 1'b0;
      wr(8'hC0);
      waitst(POSS_OFF, 8);
      wr(8'hE0);
      repeat (6) @(negedge clk_sys);
      chk(12'(power_on_request), 12'h000);
      @(posedge clk_sys);
      slow <= 1'b1;
      wantOn <= 1'b1;
      waitst(POSS_ON, 800);
      stop_test;
   end
endmodule
`default_nettype wire
